// file: pkg/dds_osc_consts.svh
// constants for the phase accumulator oscillator
`ifndef DDS_OSC_CONSTS_SVH
`define DDS_OSC_CONSTS_SVH
`define DDSO_ACC_W 20
`define DDSO_ACC_RST 20'h00000
`define DDSO_OUT_RST 1'b0
`define DDSO_PULSE_W 4
`define DDSO_PULSE_CYC_DEF 4'h1
`define DDSO_CLK_HZ 40000000
`define DDSO_ACC_MAX 21'h0fffff
`define DDSO_ACC_MOD 21'h100000
`define DDSO_FAST_INC 20'h10000
`define DDSO_GAP_MAX 5'h10
`endif

// file: pkg/ddso_pkg.sv
// types for the phase accumulator oscillator
package ddso_pkg;
  typedef enum logic [0:0] {
    DDSO_MODE_SQUARE = 1'b0,
    DDSO_MODE_PULSE = 1'b1
  } ddso_mode_t;
endpackage

// file: core/ddso_core.sv
// phase accumulator oscillator with square and pulse output modes
`timescale 1ns/100ps
`include "dds_osc_consts.svh"
// Behaviour
// - phase accumulator is a twenty-bit register whose overflow sets output period
// - every enabled clock adds the programmed increment to the accumulator
// - each accumulator carry toggles the output in square mode and sets it high in pulse mode
// - two selectable output modes: fixed duty square wave and pulse mode
// - carry rate equals clock times increment over 1048576; square output runs at half that rate
// - one increment step changes carry rate by clock over 1048576
// - square mode delivers square wave at increment-set frequency
module ddso_core (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire ddso_pkg::ddso_mode_t mode,
  input wire logic [`DDSO_ACC_W-1:0] increment,
  input wire logic [`DDSO_PULSE_W-1:0] pulse_cycles,
  output logic synthesized_output_frequency,
  output logic carry_pulse
);
  import ddso_pkg::*;

  // ==========================================================
  // accumulator
  logic [`DDSO_ACC_W-1:0] acc;
  logic [`DDSO_ACC_W-1:0] next_acc;
  logic carry;
  logic next_carry_pulse;

  // add increment each enabled clock, wrap keeps remainder
  always_comb begin
    {carry, next_acc} = {1'b0, acc} + {1'b0, increment};
    if (!enable) begin
      next_acc = acc;
      carry = 1'b0;
    end
    next_carry_pulse = carry;
  end

  // ==========================================================
  // output shaping
  logic [`DDSO_PULSE_W-1:0] pcnt;
  logic [`DDSO_PULSE_W-1:0] next_pcnt;
  logic next_out;

  // toggle in square mode, stretched pulse in pulse mode
  always_comb begin
    next_out = synthesized_output_frequency;
    next_pcnt = pcnt;
    if (!enable) begin
      next_out = `DDSO_OUT_RST;
      next_pcnt = '0;
    end else if (mode == DDSO_MODE_SQUARE) begin
      next_pcnt = '0;
      if (carry)
        next_out = ~synthesized_output_frequency;
    end else if (carry) begin
      next_out = 1'b1;
      next_pcnt = (pulse_cycles == '0) ? `DDSO_PULSE_CYC_DEF : pulse_cycles;
    end else if (pcnt > 1) begin
      next_pcnt = pcnt - 1'b1;
    end else begin
      next_pcnt = '0;
      next_out = 1'b0;
    end
  end

  // ==========================================================
  // state registers
  // accumulator group: phase value and registered carry
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      acc <= `DDSO_ACC_RST;
      carry_pulse <= 1'b0;
    end else begin
      acc <= next_acc;
      carry_pulse <= next_carry_pulse;
    end
  end

  // output group: pulse counter and output pin
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pcnt <= '0;
      synthesized_output_frequency <= `DDSO_OUT_RST;
    end else begin
      pcnt <= next_pcnt;
      synthesized_output_frequency <= next_out;
    end
  end

  // ==========================================================
  // checker helpers
  // cycles without carry while each add is at least 1/16 of the modulus
  logic [4:0] gap_cnt;
  logic [4:0] next_gap_cnt;

  // restart on carry, disable or slow increment; saturate at the top
  always_comb begin
    next_gap_cnt = gap_cnt;
    if (!enable || carry_pulse || (increment < `DDSO_FAST_INC)) begin
      next_gap_cnt = '0;
    end else if (gap_cnt != 5'h1f) begin
      next_gap_cnt = gap_cnt + 5'h01;
    end
  end

  // register the gap counter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gap_cnt <= '0;
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end

  // ==========================================================
  // assertions
  // running cycle: out of reset and enabled
  sequence s_live;
    !sys_rst && enable;
  endsequence

  // running cycle whose add overflows the accumulator
  sequence s_wrap;
    s_live ##0 ({1'b0, acc} + {1'b0, increment} > `DDSO_ACC_MAX);
  endsequence

  // running cycle whose add stays inside the accumulator
  sequence s_no_wrap;
    s_live ##0 ({1'b0, acc} + {1'b0, increment} <= `DDSO_ACC_MAX);
  endsequence

  // overflow with square mode selected
  sequence s_square_wrap;
    s_wrap ##0 (mode == DDSO_MODE_SQUARE);
  endsequence

  // no overflow with square mode selected
  sequence s_square_quiet;
    s_no_wrap ##0 (mode == DDSO_MODE_SQUARE);
  endsequence

  // overflow with pulse mode selected
  sequence s_pulse_wrap;
    s_wrap ##0 (mode == DDSO_MODE_PULSE);
  endsequence

  // pulse mode, no overflow, pulse still counting down
  sequence s_pulse_count;
    s_no_wrap ##0 (mode == DDSO_MODE_PULSE) ##0 (pcnt > 4'h1);
  endsequence

  // pulse mode, no overflow, last high cycle of the pulse
  sequence s_pulse_last;
    s_no_wrap ##0 (mode == DDSO_MODE_PULSE) ##0 (pcnt <= 4'h1);
  endsequence

  // disabled cycle out of reset
  sequence s_idle;
    !sys_rst && !enable;
  endsequence

  // every running clock adds the increment modulo the width
  a_acc_adds: assert property (@(posedge mclk) disable iff (sys_rst)
    s_live |=> acc == 20'($past(acc) + $past(increment)))
    else $error("accumulator did not add increment");

  // overflow keeps the remainder
  a_acc_wraps: assert property (@(posedge mclk) disable iff (sys_rst)
    s_wrap |=> acc == 20'(({1'b0, $past(acc)} + {1'b0, $past(increment)}) - `DDSO_ACC_MOD))
    else $error("accumulator lost remainder");

  // carry pulse follows every overflow
  a_carry_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    s_wrap |=> carry_pulse)
    else $error("carry pulse missing");

  // no carry pulse without overflow
  a_no_carry: assert property (@(posedge mclk) disable iff (sys_rst)
    s_no_wrap |=> !carry_pulse)
    else $error("spurious carry pulse");

  // square output toggles on each overflow
  a_square_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
    s_square_wrap |=> $changed(synthesized_output_frequency))
    else $error("square output did not toggle");

  // square output holds between overflows
  a_square_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    s_square_quiet |=> $stable(synthesized_output_frequency))
    else $error("square output moved without carry");

  // square mode leaves the pulse counter idle
  a_square_pcnt: assert property (@(posedge mclk) disable iff (sys_rst)
    (s_live ##0 (mode == DDSO_MODE_SQUARE)) |=> (pcnt == 4'h0))
    else $error("pulse counter busy in square mode");

  // pulse raised on each overflow
  a_pulse_high: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pulse_wrap |=> synthesized_output_frequency)
    else $error("pulse not raised on carry");

  // pulse width loaded on overflow, zero acting as one
  a_pulse_load: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pulse_wrap |=> (pcnt == (($past(pulse_cycles) == 4'h0) ?
      `DDSO_PULSE_CYC_DEF : $past(pulse_cycles))))
    else $error("pulse width not loaded");

  // pulse stays high while the counter runs down
  a_pulse_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pulse_count |=> synthesized_output_frequency && (pcnt == $past(pcnt) - 4'h1))
    else $error("pulse dropped early");

  // pulse falls after its last high cycle
  a_pulse_end: assert property (@(posedge mclk) disable iff (sys_rst)
    s_pulse_last |=> !synthesized_output_frequency && (pcnt == 4'h0))
    else $error("pulse did not end");

  // disabled: output low and accumulator frozen
  a_idle_low: assert property (@(posedge mclk) disable iff (sys_rst)
    s_idle |=> !synthesized_output_frequency && $stable(acc))
    else $error("disabled oscillator active");

  // disabled: no carry and no pulse in flight
  a_idle_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    s_idle |=> !carry_pulse && (pcnt == 4'h0))
    else $error("disabled oscillator carried");

  // reset clears every state bit
  a_reset_clear: assert property (@(posedge mclk)
    sys_rst |=> (acc == `DDSO_ACC_RST) && !carry_pulse && (pcnt == 4'h0)
      && !synthesized_output_frequency)
    else $error("reset left state behind");

  // a fast increment must carry within sixteen adds
  a_carry_due: assert property (@(posedge mclk) disable iff (sys_rst)
    (gap_cnt <= `DDSO_GAP_MAX))
    else $error("carry overdue for fast increment");

endmodule // ddso_core

// file: bench/ddso_filter_model.sv
// filter stand-in: counts transitions of the oscillator output in either mode
`timescale 1ns/100ps
module ddso_filter_model (
  input wire logic mclk,
  input wire logic sig,
  output int edges
);
  logic last = 1'b0;
  initial edges = 0;
  // one count per level change seen at the filter input
  always @(posedge mclk) begin
    if (sig !== last) edges++;
    last <= sig;
  end
endmodule // ddso_filter_model

// file: bench/tb_phase_accumulator_oscillator.sv
// self-checking bench for the phase accumulator oscillator
`timescale 1ns/100ps
module tb_phase_accumulator_oscillator;
  import ddso_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, en = 1'b0, out, car;
  ddso_mode_t md = DDSO_MODE_SQUARE;
  logic [19:0] inc = 20'h00000;
  logic [3:0] pw = 4'h1;
  int error_cnt = 0, cmp_count = 0, n_car, n_hi, e0, edges;
  always #12.5 mclk = ~mclk;
  ddso_core i_dut (.mclk(mclk), .sys_rst(sys_rst), .enable(en), .mode(md), .increment(inc),
    .pulse_cycles(pw), .synthesized_output_frequency(out), .carry_pulse(car));
  ddso_filter_model i_filt (.mclk(mclk), .sig(out), .edges(edges));
  // settle 40 cycles, then count carries and high cycles over 64
  task automatic run(input ddso_mode_t m, input logic [19:0] i, input logic [3:0] p,
    input logic e);
    @(posedge mclk);
    md <= m;
    en <= e;
    inc <= i;
    pw <= p;
    repeat (40) @(posedge mclk);
    #1;
    n_car = 0;
    n_hi = 0;
    e0 = edges;
    repeat (64) begin
      @(posedge mclk);
      #1;
      n_car += (car === 1'b1);
      n_hi += (out === 1'b1);
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // carry every 16 cycles, output toggles on each
  task automatic t_square();
    run(DDSO_MODE_SQUARE, 20'h10000, 4'h1, 1'b1);
    chk(n_car, 4);
    chk(edges - e0, 4);
    chk(n_hi, 32);
  endtask
  // 3/8 step: remainder kept gives 24 carries in 64
  task automatic t_wrap();
    run(DDSO_MODE_SQUARE, 20'h60000, 4'h1, 1'b1);
    chk(n_car, 24);
  endtask
  // pulse mode: 3-cycle high pulse per carry, width 0 acts as 1
  task automatic t_pulse();
    run(DDSO_MODE_PULSE, 20'h10000, 4'h3, 1'b1);
    chk(n_hi, 12);
    chk(n_car, 4);
    chk(edges - e0, 8);
    run(DDSO_MODE_PULSE, 20'h10000, 4'h0, 1'b1);
    chk(n_hi, 4);
  endtask
  // mid-run reset: acc restarts at zero, first carry two edges after release
  task automatic t_reset();
    @(posedge mclk);
    md <= DDSO_MODE_SQUARE;
    inc <= 20'h80000;
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk({out, car}, 2'h0);
    @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({out, car}, 2'h0);
    @(posedge mclk);
    #1;
    chk({out, car}, 2'h3);
    @(posedge mclk);
    #1;
    chk({out, car}, 2'h2);
    @(posedge mclk);
    #1;
    chk({out, car}, 2'h1);
  endtask
  // disabled: accumulator frozen, output low, no carries
  task automatic t_idle();
    run(DDSO_MODE_SQUARE, 20'h10000, 4'h1, 1'b0);
    chk(n_car, 0);
    chk(n_hi, 0);
    chk(edges - e0, 0);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog well past the ~540-cycle run
  initial begin
    #25000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_square();
    t_wrap();
    t_pulse();
    t_reset();
    t_idle();
    report_and_stop();
  end
endmodule // tb_phase_accumulator_oscillator
